// ==== hdl/cwgsd_consts.svh ====
// Register offsets, field positions, reset values and encodings of the
// steering, shutdown and rising dead-band block.
// Assumes byte addressing with one aligned 32-bit word per register.
`ifndef CWGSD_CONSTS_SVH
`define CWGSD_CONSTS_SVH
`define CWGSD_OFF_STEER 8'h00
`define CWGSD_OFF_SD0 8'h04
`define CWGSD_OFF_SRC 8'h08
`define CWGSD_OFF_DBR 8'h0C
`define CWGSD_OFF_CTRL 8'h10
`define CWGSD_OFF_POL 8'h14
`define CWGSD_SD_BIT 7
`define CWGSD_REN_BIT 6
`define CWGSD_EN_BIT 7
`define CWGSD_IN_BIT 5
`define CWGSD_STEER_RST 8'h00
`define CWGSD_SD0_RST 8'h14
`define CWGSD_SRC_RST 5'h00
`define CWGSD_DBR_RST 6'h00
`define CWGSD_POL_RST 4'h0
`define CWGSD_LVL_ONE 2'h3
`define CWGSD_LVL_ZERO 2'h2
`define CWGSD_LVL_TRI 2'h1
`define CWGSD_LVL_INACT 2'h0
`define CWGSD_RESP_OKAY 2'h0
`define CWGSD_RESP_SLVERR 2'h2
`endif

// ==== hdl/cwgsd_pkg.sv ====
// Types shared by the steering and shutdown block.
// Assumes nothing beyond a SystemVerilog compiler.
package cwgsd_pkg;
  typedef enum logic [2:0] {
    CWGSD_ASYNC_STEER = 3'h0,
    CWGSD_SYNC_STEER = 3'h1,
    CWGSD_FWD_BRIDGE = 3'h2,
    CWGSD_REV_BRIDGE = 3'h3,
    CWGSD_HALF_BRIDGE = 3'h4,
    CWGSD_PUSH_PULL = 3'h5
  } cwgsd_mode_t;

  // Field order matches the source enable bits, bit 4 down to bit 0.
  typedef struct packed {
    logic cell4;
    logic cell2;
    logic cmp2;
    logic cmp1;
    logic pin;
  } cwgsd_src_t;
endpackage : cwgsd_pkg

// ==== hdl/cwgsd_deadband.sv ====
// Rising-edge dead-band delay of the data waveform.
// Assumes data_in is synchronous to aclk; with a nonzero count, falling edges pass one clock later.
`timescale 1ns/1ps
module cwgsd_deadband #(
  parameter int DB_W = 6
) (
  input logic aclk, // Generator clock
  input logic aresetn, // Synchronous reset, active low
  input logic data_in, // Data waveform
  input logic [DB_W-1:0] count, // Rising dead-band count
  output logic data_out // Delayed waveform
);
  logic [DB_W-1:0] cnt_r;
  logic out_r;

  // The counter reloads while the input is low, so a nonzero count written
  // mid-pulse applies from the next rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (!data_in) begin
      cnt_r <= count;
      out_r <= 1'b0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      out_r <= 1'b1;
    end
  end

  assign data_out = (count == '0) ? data_in : out_r;

  property p_db_hold;
    @(posedge aclk) disable iff (!aresetn)
      (count != '0 && cnt_r != '0) |-> !data_out;
  endproperty
  a_db_hold: assert property (p_db_hold)
    else $error("rising edge passed before dead-band count ran out");

  property p_db_bypass;
    @(posedge aclk) disable iff (!aresetn)
      (count == '0) |-> (data_out == data_in);
  endproperty
  a_db_bypass: assert property (p_db_bypass)
    else $error("zero dead-band count did not bypass");
endmodule : cwgsd_deadband

// ==== hdl/cwgsd_level.sv ====
// Level and drive enable of one output from steering and shutdown state.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`include "cwgsd_consts.svh"
module cwgsd_level (
  input logic steering, // Mode is one of the steering modes
  input logic steer_en, // Output follows the waveform
  input logic override, // Static level when not steered
  input logic invert, // Output polarity
  input logic wave, // Dead-banded data waveform
  input logic enable, // Module enable
  input logic shut, // Shutdown state in effect
  input logic [1:0] code, // Shutdown level code of this pair
  output logic level, // Pin level
  output logic oe // Pin drive enable
);
  always_comb begin
    level = 1'b0;
    oe = 1'b1;
    if (shut) begin
      unique case (code)
        `CWGSD_LVL_ONE: level = 1'b1;
        `CWGSD_LVL_ZERO: level = 1'b0;
        `CWGSD_LVL_TRI: oe = 1'b0;
        default: level = invert;
      endcase
    end else if (!enable) begin
      level = 1'b0;
    end else if (steering && !steer_en) begin
      level = override;
    end else begin
      level = wave ^ invert;
    end
  end
endmodule : cwgsd_level

// ==== hdl/cwgsd_top.sv ====
// Output stage of the complementary waveform generator: steering,
// auto-shutdown with restart, rising dead-band, and an AXI4-Lite slave.
// Assumes data_in and the shutdown sources are synchronous to aclk.
//
// Summary of operation
// - Steered output carries data waveform adjusted by its own polarity bit.
// - Unsteered output is driven with its static override level.
// - Steering bits act only in the two steering modes.
// - In synchronous steering the enable bits are double-buffered.
// - Shutdown bit reads one until the event is cleared; it reads zero while outputs still wait for the data edge.
// - Restart bit picks hardware restart when one, software when zero.
// - Odd-pair code: 11 high, 10 low, 01 tri-state during shutdown.
// - Even-pair code uses the same encoding for its own outputs.
// - Code 00 gives inactive level with polarity after dead-band interval.
// - Outputs stay shut after clear until next data rising edge.
// - Five source enables: cell four, cell two, cmp two, cmp one, pin.
// - Upper three bits of source enable register read zero.
// - Rising edge delayed by N+1 clocks for a nonzero count N, six-bit count.
// - Zero rising count bypasses the dead-band.
// - With restart enabled hardware clears shutdown once causes are gone.
// - Software clear of shutdown is ignored while a cause remains.
// - Mode 000 is asynchronous steering, 001 synchronous steering.
`timescale 1ns/1ps
`include "cwgsd_consts.svh"
module cwgsd_top #(
  parameter int ADDR_W = 8,
  parameter int DB_W = 6
) (
  input logic aclk, // Generator clock, 200 MHz
  input logic aresetn, // Synchronous reset, active low
  input logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input logic [31:0] s_axi_wdata, // Write data
  input logic [3:0] s_axi_wstrb, // Write byte enables
  input logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input logic s_axi_bready, // Write response ready
  input logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input logic s_axi_rready, // Read data ready
  input logic data_in, // Generator data input waveform
  input cwgsd_pkg::cwgsd_src_t shutdown_src, // Shutdown source levels
  output logic [3:0] wave_out, // Output levels, out0 to out3
  output logic [3:0] wave_oe // Output drive enables, high drives
);
  localparam logic [2:0] IDX_STEER = 3'h0;
  localparam logic [2:0] IDX_SD0 = 3'h1;
  localparam logic [2:0] IDX_SRC = 3'h2;
  localparam logic [2:0] IDX_DBR = 3'h3;
  localparam logic [2:0] IDX_CTRL = 3'h4;
  localparam logic [2:0] IDX_POL = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam logic [7:0] SD0_RST = `CWGSD_SD0_RST;

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    unique case (lo)
      `CWGSD_OFF_STEER: reg_index = IDX_STEER;
      `CWGSD_OFF_SD0: reg_index = IDX_SD0;
      `CWGSD_OFF_SRC: reg_index = IDX_SRC;
      `CWGSD_OFF_DBR: reg_index = IDX_DBR;
      `CWGSD_OFF_CTRL: reg_index = IDX_CTRL;
      `CWGSD_OFF_POL: reg_index = IDX_POL;
      default: reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic wr_fire;
  logic [2:0] wr_idx;
  logic wr_ok;
  logic [2:0] rd_idx;
  logic [7:0] steer_r;
  logic [3:0] str_act_r;
  logic sd_r;
  logic ren_r;
  logic [1:0] shutdown_level_pair_odd_r;
  logic [1:0] shutdown_level_pair_even_r;
  logic [4:0] ase_r;
  logic [DB_W-1:0] dbr_r;
  logic en_r;
  cwgsd_pkg::cwgsd_mode_t mode_r;
  logic [3:0] pol_r;
  logic data_q;
  logic rise;
  logic cond;
  logic hold_r;
  logic shut;
  logic shut_q;
  logic [DB_W-1:0] sd_wait_r;
  logic start_wait;
  logic steering;
  logic db_wave;
  logic [3:0] str_eff;
  logic [3:0] lvl;
  logic [3:0] oe;

  // Write channels are taken independently; ready drops while one is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = reg_index(awaddr_r);
  assign wr_ok = wr_fire && wstrb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CWGSD_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == IDX_NONE) ? `CWGSD_RESP_SLVERR
                                          : `CWGSD_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign rd_idx = reg_index(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CWGSD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CWGSD_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (rd_idx)
        IDX_STEER: s_axi_rdata[7:0] <= steer_r;
        IDX_SD0: s_axi_rdata[7:0] <= {sd_r, ren_r, shutdown_level_pair_odd_r, shutdown_level_pair_even_r, 2'h0};
        IDX_SRC: s_axi_rdata[7:0] <= {3'h0, ase_r};
        IDX_DBR: s_axi_rdata[DB_W-1:0] <= dbr_r;
        IDX_CTRL: s_axi_rdata[7:0] <= {en_r, 4'h0, mode_r};
        IDX_POL: s_axi_rdata[7:0] <= {2'h0, data_in, 1'b0, pol_r};
        default: s_axi_rresp <= `CWGSD_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      steer_r <= `CWGSD_STEER_RST;
    end else if (wr_ok && wr_idx == IDX_STEER) begin
      steer_r <= wdata_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ren_r <= SD0_RST[`CWGSD_REN_BIT];
      shutdown_level_pair_odd_r <= SD0_RST[5:4];
      shutdown_level_pair_even_r <= SD0_RST[3:2];
      ase_r <= `CWGSD_SRC_RST;
      dbr_r <= `CWGSD_DBR_RST;
      en_r <= 1'b0;
      mode_r <= cwgsd_pkg::CWGSD_ASYNC_STEER;
      pol_r <= `CWGSD_POL_RST;
    end else if (wr_ok) begin
      unique case (wr_idx)
        IDX_SD0: begin
          ren_r <= wdata_r[`CWGSD_REN_BIT];
          shutdown_level_pair_odd_r <= wdata_r[5:4];
          shutdown_level_pair_even_r <= wdata_r[3:2];
        end
        IDX_SRC: ase_r <= wdata_r[4:0];
        IDX_DBR: dbr_r <= wdata_r[DB_W-1:0];
        IDX_CTRL: begin
          en_r <= wdata_r[`CWGSD_EN_BIT];
          mode_r <= cwgsd_pkg::cwgsd_mode_t'(wdata_r[2:0]);
        end
        IDX_POL: pol_r <= wdata_r[3:0];
        default: ;
      endcase
    end
  end

  assign rise = data_in && !data_q;
  assign cond = |(shutdown_src & ase_r);
  assign steering = (mode_r == cwgsd_pkg::CWGSD_ASYNC_STEER) ||
                    (mode_r == cwgsd_pkg::CWGSD_SYNC_STEER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= 1'b0;
    end else begin
      data_q <= data_in;
    end
  end

  // Active enables follow the written value in asynchronous steering and
  // only on a data rising edge otherwise, so a mode switch starts clean.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      str_act_r <= 4'h0;
    end else if (mode_r == cwgsd_pkg::CWGSD_ASYNC_STEER || rise) begin
      str_act_r <= steer_r[3:0];
    end
  end

  assign str_eff = (mode_r == cwgsd_pkg::CWGSD_SYNC_STEER) ? str_act_r
                                                           : steer_r[3:0];

  // A source event outranks a software clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_r <= 1'b0;
    end else if (cond) begin
      sd_r <= 1'b1;
    end else if (wr_ok && wr_idx == IDX_SD0) begin
      sd_r <= wdata_r[`CWGSD_SD_BIT];
    end else if (ren_r) begin
      sd_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 1'b0;
    end else if (sd_r) begin
      hold_r <= 1'b1;
    end else if (rise) begin
      hold_r <= 1'b0;
    end
  end

  assign shut = sd_r || hold_r;
  // The freeze starts in the entry cycle, before the wait count is loaded.
  assign start_wait = shut && !shut_q && dbr_r != '0;

  // Code 00 outputs keep their last level for the rising dead-band
  // interval after shutdown starts, so the switch pair never overlaps.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shut_q <= 1'b0;
      sd_wait_r <= '0;
    end else begin
      shut_q <= shut;
      if (shut && !shut_q) begin
        sd_wait_r <= dbr_r;
      end else if (sd_wait_r != '0) begin
        sd_wait_r <= sd_wait_r - 1'b1;
      end
    end
  end

  cwgsd_deadband #(
    .DB_W(DB_W)
  ) u_deadband (
    .aclk(aclk),
    .aresetn(aresetn),
    .data_in(data_in),
    .count(dbr_r),
    .data_out(db_wave)
  );

  for (genvar i = 0; i < 4; i++) begin : g_out
    logic [1:0] code;
    logic wait_here;
    assign code = (i % 2 == 1) ? shutdown_level_pair_odd_r : shutdown_level_pair_even_r;
    assign wait_here = shut && code == `CWGSD_LVL_INACT &&
                       (start_wait || sd_wait_r != '0);

    cwgsd_level u_level (
      .steering(steering),
      .steer_en(str_eff[i]),
      .override(steer_r[4+i]),
      .invert(pol_r[i]),
      .wave(db_wave),
      .enable(en_r),
      .shut(shut),
      .code(code),
      .level(lvl[i]),
      .oe(oe[i])
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave_out[i] <= 1'b0;
        wave_oe[i] <= 1'b1;
      end else if (!wait_here) begin
        wave_out[i] <= lvl[i];
        wave_oe[i] <= oe[i];
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sd_set;
    cond |=> sd_r;
  endproperty
  a_sd_set: assert property (p_sd_set)
    else $error("enabled source did not set shutdown");

  property p_sw_clr_ignored;
    (cond && wr_ok && wr_idx == IDX_SD0 && !wdata_r[7]) |=> sd_r ##1 shut;
  endproperty
  a_sw_clr_ignored: assert property (p_sw_clr_ignored)
    else $error("shutdown cleared while a cause remained");

  property p_auto_restart;
    (sd_r && ren_r && !cond && !(wr_ok && wr_idx == IDX_SD0)) |=> !sd_r;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto restart did not clear shutdown");

  property p_stay_shut;
    (shut && !sd_r && !rise) |=> shut;
  endproperty
  a_stay_shut: assert property (p_stay_shut)
    else $error("shutdown left without a data rising edge");

  property p_steer_wave;
    (en_r && !shut && steering && str_eff[0])
      |=> wave_out[0] == ($past(db_wave) ^ $past(pol_r[0])) && wave_oe[0];
  endproperty
  a_steer_wave: assert property (p_steer_wave)
    else $error("steered output does not follow waveform");

  property p_steer_ovr;
    (en_r && !shut && steering && !str_eff[1])
      |=> wave_out[1] == $past(steer_r[5]);
  endproperty
  a_steer_ovr: assert property (p_steer_ovr)
    else $error("unsteered output not at override level");

  property p_sync_buffer;
    (mode_r == cwgsd_pkg::CWGSD_SYNC_STEER && !rise) |=> $stable(str_act_r);
  endproperty
  a_sync_buffer: assert property (p_sync_buffer)
    else $error("synchronous steering changed without data edge");

  property p_sync_load;
    rise |=> str_act_r == $past(steer_r[3:0]);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("steering buffer not loaded on data edge");

  property p_tristate;
    (shut && shutdown_level_pair_odd_r == `CWGSD_LVL_TRI) |=> !wave_oe[1] && !wave_oe[3];
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("odd pair not released in tri-state shutdown");

  property p_force_high;
    (shut && shutdown_level_pair_even_r == `CWGSD_LVL_ONE) |=> wave_out[0] && wave_out[2];
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("even pair not high in shutdown");

  c_shutdown: cover property (!sd_r ##1 sd_r);
  c_restart: cover property (sd_r && ren_r ##1 !sd_r ##[1:50] !shut);
  c_sync_load: cover property (
    mode_r == cwgsd_pkg::CWGSD_SYNC_STEER && rise && steer_r[3:0] != str_act_r);
  c_inact_wait: cover property (shut && sd_wait_r != '0);
endmodule : cwgsd_top

// ==== sim/cwgsd_far_side.sv ====
// Far-side model: data waveform source, shutdown sources and pin loads.
// Assumes the bench commands levels; the model launches them after an edge.
`timescale 1ns/1ps
module cwgsd_far_side (
  input logic aclk, // Generator clock
  input logic data_cmd, // Requested data level
  input logic [4:0] src_cmd, // Requested shutdown source levels
  input logic [3:0] wave_out, // Output levels from the block
  input logic [3:0] wave_oe, // Output drive enables
  output logic data_in, // Data waveform to the block
  output cwgsd_pkg::cwgsd_src_t shutdown_src, // Shutdown sources
  output logic [3:0] pin // Pin level seen by the switch drivers
);
  logic [3:0] last_r;
  initial begin
    data_in = 1'b0;
    shutdown_src = '0;
    last_r = 4'h0;
  end
  always @(posedge aclk) begin
    data_in <= data_cmd;
    shutdown_src <= src_cmd;
    for (int i = 0; i < 4; i++) begin
      if (wave_oe[i]) begin
        last_r[i] <= wave_out[i];
      end
    end
  end
  // A released pin shows the inverse of its last level, so a check that
  // ignores the drive enable cannot pass by luck.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = wave_oe[i] ? wave_out[i] : ~last_r[i];
    end
  end
endmodule : cwgsd_far_side

// ==== sim/cwg_steer_shutdown_deadband_test.sv ====
// Bench for the steering, shutdown and dead-band block over AXI4-Lite.
// Assumes registered AXI answers and the far-side model beside the block.
`timescale 1ns/1ps
`include "cwgsd_consts.svh"
module cwg_steer_shutdown_deadband_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0, wave_out, wave_oe, pin;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, data_cmd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, data_in;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] src_cmd = 5'h00;
  cwgsd_pkg::cwgsd_src_t shutdown_src;
  int n_mismatch = 0, checked = 0, cyc = 0, k, e;
  logic [7:0] e_n [3] = '{8'h00, 8'h01, 8'h3F};

  always #2.5 aclk = ~aclk;

  cwgsd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_in(data_in),
    .shutdown_src(shutdown_src), .wave_out(wave_out), .wave_oe(wave_oe));

  cwgsd_far_side far (.aclk(aclk), .data_cmd(data_cmd), .src_cmd(src_cmd),
    .wave_out(wave_out), .wave_oe(wave_oe), .data_in(data_in),
    .shutdown_src(shutdown_src), .pin(pin));

  task automatic close_out();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Both write channels are offered together; each drops when taken.
  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s = 4'hF);
    bit awd, wd, bd;
    awd = 0;
    wd = 0;
    bd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge aclk);
      if (awready && !awd) begin
        awvalid <= 1'b0;
        awd = 1;
      end
      if (wready && !wd) begin
        wvalid <= 1'b0;
        wd = 1;
      end
      if (bvalid && awd && wd) begin
        resp = bresp;
        bready <= 1'b0;
        bd = 1;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    bit ard, rdn;
    ard = 0;
    rdn = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rdn) begin
      @(posedge aclk);
      if (arready && !ard) begin
        arvalid <= 1'b0;
        ard = 1;
      end
      if (rvalid && ard) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        rdn = 1;
      end
    end
  endtask : axr

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    axr(a);
    chk(rd, {24'h0, x});
  endtask : rdc

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w

  initial begin
    w(12);
    aresetn <= 1'b1;
    chk(wave_oe, 4'hF);
    rdc(`CWGSD_OFF_STEER, 8'h00);
    rdc(`CWGSD_OFF_SD0, 8'h14);
    rdc(`CWGSD_OFF_SRC, 8'h00);
    rdc(`CWGSD_OFF_DBR, 8'h00);
    rdc(`CWGSD_OFF_POL, 8'h00);
    chk(resp, `CWGSD_RESP_OKAY);
    axr(8'h18);
    chk(resp, `CWGSD_RESP_SLVERR);
    axw(8'h18, 8'hFF);
    chk(resp, `CWGSD_RESP_SLVERR);
    axw(`CWGSD_OFF_SRC, 8'hFF);
    chk(resp, `CWGSD_RESP_OKAY);
    rdc(`CWGSD_OFF_SRC, 8'h1F);
    axw(`CWGSD_OFF_STEER, 8'h63, 4'h0);
    rdc(`CWGSD_OFF_STEER, 8'h00);
    axw(`CWGSD_OFF_STEER, 8'h63);
    axw(`CWGSD_OFF_POL, 8'h05);
    for (int c = 0; c < 4; c++) begin
      axw(`CWGSD_OFF_SD0, {2'b10, c[1:0], c[1:0], 2'b00});
      w(3);
      if (c == 1) chk(wave_oe, 4'h0);
      else chk(pin, c == 3 ? 4'hF : c == 2 ? 4'h0 : 4'h5);
    end
    axw(`CWGSD_OFF_SD0, 8'hBC);
    axw(`CWGSD_OFF_CTRL, 8'h80);
    axw(`CWGSD_OFF_SD0, 8'h3C);
    w(3);
    chk(pin, 4'hF);
    data_cmd <= 1'b1;
    w(4);
    chk(pin, 4'h6);
    data_cmd <= 1'b0;
    w(4);
    chk(pin, 4'h5);
    axw(`CWGSD_OFF_CTRL, 8'h85);
    w(3);
    chk(pin, 4'h5);
    data_cmd <= 1'b1;
    w(4);
    chk(pin, 4'hA);
    rdc(`CWGSD_OFF_POL, 8'h25);
    data_cmd <= 1'b0;
    axw(`CWGSD_OFF_CTRL, 8'h80);
    foreach (e_n[i]) begin
      axw(`CWGSD_OFF_DBR, e_n[i]);
      data_cmd <= 1'b1;
      k = 0;
      e = e_n[i] == 0 ? 3 : e_n[i] + 4;
      while (pin[1] !== 1'b1 && k < 80) begin
        @(posedge aclk);
        k++;
      end
      chk(k >= e - 1 && k <= e, 1);
      data_cmd <= 1'b0;
      w(4);
      chk(pin[1], 1'b0);
    end
    axw(`CWGSD_OFF_DBR, 8'h00);
    axw(`CWGSD_OFF_SD0, 8'h3C);
    for (int i = 0; i < 5; i++) begin
      src_cmd <= 5'h01 << i;
      w(3);
      rdc(`CWGSD_OFF_SD0, 8'hBC);
      axw(`CWGSD_OFF_SD0, 8'h3C);
      rdc(`CWGSD_OFF_SD0, 8'hBC);
      src_cmd <= 5'h00;
      w(2);
      axw(`CWGSD_OFF_SD0, 8'h3C);
      rdc(`CWGSD_OFF_SD0, 8'h3C);
    end
    axw(`CWGSD_OFF_SRC, 8'h1E);
    src_cmd <= 5'h01;
    w(3);
    rdc(`CWGSD_OFF_SD0, 8'h3C);
    src_cmd <= 5'h00;
    axw(`CWGSD_OFF_SD0, 8'h7C);
    src_cmd <= 5'h02;
    w(3);
    rdc(`CWGSD_OFF_SD0, 8'hFC);
    chk(pin, 4'hF);
    src_cmd <= 5'h00;
    w(3);
    rdc(`CWGSD_OFF_SD0, 8'h7C);
    chk(pin, 4'hF);
    data_cmd <= 1'b1;
    w(4);
    chk(pin, 4'h6);
    axw(`CWGSD_OFF_CTRL, 8'h81);
    data_cmd <= 1'b0;
    w(3);
    data_cmd <= 1'b1;
    w(3);
    data_cmd <= 1'b0;
    axw(`CWGSD_OFF_STEER, 8'h6C);
    w(3);
    chk(pin, 4'h5);
    data_cmd <= 1'b1;
    w(4);
    chk(pin, 4'hA);
    axw(`CWGSD_OFF_DBR, 8'h08);
    axw(`CWGSD_OFF_SD0, 8'h40);
    src_cmd <= 5'h02;
    w(6);
    chk(pin, 4'hA);
    w(8);
    chk(pin, 4'h5);
    close_out();
  end

endmodule : cwg_steer_shutdown_deadband_test
